// ==== shared/bec_cfg.svh ====
`ifndef BEC_CFG_SVH
`define BEC_CFG_SVH
// Register offsets on the serial control bus
`define BEC_OFF_DATA0 8'h4b
`define BEC_OFF_DATA2 8'h4d
`define BEC_OFF_DATA3 8'h4e
`define BEC_OFF_CTL 8'h4f
`define BEC_OFF_STS 8'h50
`define BEC_OFF_ID 8'h51
`define BEC_OFF_TIMA 8'h52
`define BEC_OFF_TIMB 8'h53
// Bridge control fields
`define BEC_CTL_CLK_SRC 4
`define BEC_CTL_CLK_EN 3
`define BEC_CTL_CLEAR 2
`define BEC_CTL_RELOAD 1
`define BEC_CTL_BLOCK 0
// Bridge status fields
`define BEC_STS_PWR 7
`define BEC_STS_RXINT 6
`define BEC_STS_INIT_DONE 4
`define BEC_STS_REMOTE 3
`define BEC_STS_CFG_DONE 2
`define BEC_STS_CFG_CK 1
`define BEC_STS_ID_CK 0
// Reset values
`define BEC_RST_DATA 8'h00
`define BEC_RST_ID 8'ha0
`define BEC_RST_HOLD 3'h1
`define BEC_RST_FILTER 4'he
`define BEC_RST_DELAY 2'h0
// Writable masks; reserved bits drop writes
`define BEC_MASK_CTL 8'h1e
`define BEC_MASK_TIMA 8'h7f
`define BEC_MASK_TIMB 8'h03
// Timing figures and cycle counts at 20 MHz
`define BEC_CLK_NS 50
`define BEC_HOLD_UNIT_NS 40
`define BEC_FILTER_UNIT_NS 5
`define BEC_DELAY_BASE_NS 240
`define BEC_DELAY_STEP_NS 40
// Memory geometry and checksum spans
`define BEC_MEM_WORDS 256
`define BEC_ID_SPAN 256
`define BEC_CFG_SPAN 128
`endif

// ==== shared/bec_pkg.sv ====
package bec_pkg;
  typedef struct packed {
    logic clk_src;
    logic clk_en;
    logic clear;
    logic reload;
    logic block;
  } bec_ctl_s;
  typedef struct packed {
    logic [2:0] hold;
    logic [3:0] filter;
    logic [1:0] delay;
    logic [6:0] slave;
    logic write_protect;
  } bec_chan_s;
  typedef enum logic [2:0] {
    BEC_IDLE, BEC_CFG, BEC_WIPE, BEC_LOAD, BEC_SUM, BEC_DONE
  } bec_init_e;
endpackage

// ==== core/bec_mem.sv ====
`timescale 1ns/1ps
module bec_mem
  import bec_pkg::*;
#(
  parameter int DW = 8,
  parameter int AW = 8
)
(
  // Clock
  input wire logic mclk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Contents have no reset; the init engine wipes or loads them
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ==== core/bec_sync.sv ====
`timescale 1ns/1ps
module bec_sync
  import bec_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // Only the second stage is read outside
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ==== core/bec_regs.sv ====
`timescale 1ns/1ps
`include "bec_cfg.svh"
module bec_regs
  import bec_pkg::*;
#(
  parameter int MEM_AW = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port from the serial control bus slave
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Indirect bus engine: read start and completion
  input wire logic ind_read_start,
  input wire logic ind_read_done,
  input wire logic [31:0] ind_read_data,
  // Pins, asynchronous
  input wire logic strap_pin_zero,
  input wire logic five_volt_detect_pin,
  input wire logic rx_int_pin,
  // Status from configuration and remote loader
  input wire logic cfg_auto_done,
  input wire logic remote_load_pulse,
  // Byte stream from the identification EEPROM
  input wire logic ee_valid,
  input wire logic [7:0] ee_data,
  input wire logic ee_last,
  output logic ee_ready,
  output logic ee_start,
  // Display data channel side of the memory
  input wire logic chan_rd,
  input wire logic chan_wr,
  input wire logic [MEM_AW-1:0] chan_addr,
  input wire logic [7:0] chan_wdata,
  output logic [7:0] chan_rdata,
  output logic chan_ack_n,
  // Settings driven to the channel and clock logic
  output bec_chan_s chan_cfg,
  output logic consumer_ctl_clock_enable,
  output logic consumer_ctl_clock_source,
  // Derived timing in clock cycles
  output logic [7:0] hold_cycles,
  output logic [7:0] filter_cycles,
  output logic [7:0] delay_cycles
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins
  logic [2:0] pins_s;
  bec_sync #(.W(3)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({strap_pin_zero, five_volt_detect_pin, rx_int_pin}),
    .sync_out(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] data0_q, data0_d, data2_q, data2_d, data3_q, data3_d;
  bec_ctl_s ctl_q, ctl_d;
  bec_chan_s chn_q, chn_d;
  logic [1:0] strap_wait_q, strap_wait_d;
  logic cfg_done_q, cfg_done_d, init_done_q, init_done_d;
  logic remote_q, remote_d, cfg_ck_q, cfg_ck_d, id_ck_q, id_ck_d;
  bec_init_e st_q, st_d;
  logic [8:0] cnt_q, cnt_d;
  logic [7:0] sum_q, sum_d, cfg_sum_q, cfg_sum_d;
  logic [7:0] rdata_q, rdata_d;

  // Address match for one offset, used by writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Memory and its two users
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr, mem_raddr;
  logic [7:0] mem_wdata, mem_rdata;
  bec_mem #(.DW(8), .AW(MEM_AW)) u_mem (
    .mclk(mclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  logic busy;
  logic chan_ok;
  assign busy = (st_q == BEC_WIPE) || (st_q == BEC_LOAD);
  // Channel is refused while blocked or while init owns the memory
  assign chan_ok = !ctl_q.block && !busy;

  // Memory port arbitration: init engine wins, channel waits
  always_comb
  begin
    mem_we = 1'b0;
    mem_waddr = chan_addr;
    mem_wdata = chan_wdata;
    mem_raddr = chan_addr;
    if (st_q == BEC_WIPE)
    begin
      mem_we = 1'b1;
      mem_waddr = cnt_q[MEM_AW-1:0];
      mem_wdata = 8'h00;
    end
    else if (st_q == BEC_LOAD)
    begin
      mem_we = ee_valid && !cnt_q[8];
      mem_waddr = cnt_q[MEM_AW-1:0];
      mem_wdata = ee_data;
    end
    else if (chan_ok && chan_wr && !chn_q.write_protect)
    begin
      mem_we = 1'b1;
    end
  end

  // Channel answers: data follows chan_addr one cycle later, with or without chan_rd; ack low when taken
  assign chan_rdata = mem_rdata;
  assign chan_ack_n = !(chan_ok && (chan_rd || (chan_wr && !chn_q.write_protect)));

  ////////////////////////////////////////////////////////////////////////////
  // Init engine: wipe, or load and then checksum result
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    cfg_sum_d = cfg_sum_q;
    id_ck_d = id_ck_q;
    cfg_ck_d = cfg_ck_q;
    ee_start = 1'b0;
    ee_ready = 1'b0;
    case (st_q)
      BEC_IDLE:
      begin
        if (ctl_q.reload)
        begin
          cnt_d = '0;
          sum_d = '0;
          cfg_sum_d = '0;
          ee_start = !ctl_q.clear;
          st_d = ctl_q.clear ? BEC_WIPE : BEC_LOAD;
        end
      end
      BEC_WIPE:
      begin
        cnt_d = cnt_q + 9'd1;
        if (cnt_q == 9'(`BEC_MEM_WORDS - 1))
        begin
          st_d = BEC_DONE;
        end
      end
      BEC_LOAD:
      begin
        ee_ready = 1'b1;
        if (ee_valid)
        begin
          cnt_d = cnt_q + 9'd1;
          // Ident sum covers the first span, config sum the last bytes
          if (cnt_q < 9'(`BEC_ID_SPAN))
          begin
            sum_d = sum_q + ee_data;
          end
          cfg_sum_d = cfg_sum_q + ee_data;
          if (ee_last)
          begin
            st_d = BEC_SUM;
          end
        end
      end
      BEC_SUM:
      begin
        id_ck_d = (sum_q == 8'h00);
        cfg_ck_d = (cfg_sum_q == 8'h00);
        st_d = BEC_DONE;
      end
      BEC_DONE:
      begin
        st_d = BEC_IDLE;
      end
      default:
      begin
        st_d = BEC_IDLE;
      end
    endcase
    // Config span restarts so only the last bytes remain in the sum
    if (st_q == BEC_LOAD && ee_valid && cnt_q[6:0] == 7'h7f)
    begin
      cfg_sum_d = 8'h00;
      if (ee_last)
      begin
        cfg_sum_d = cfg_sum_q + ee_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, self-clearing bits and status flags
  always_comb
  begin
    data0_d = data0_q;
    data2_d = data2_q;
    data3_d = data3_q;
    ctl_d = ctl_q;
    chn_d = chn_q;
    // Follow the strap until both sync stages hold the pin, then freeze it
    strap_wait_d = strap_wait_q;
    if (strap_wait_q != 2'h3)
    begin
      strap_wait_d = strap_wait_q + 2'h1;
      ctl_d.block = pins_s[2];
    end
    if (ind_read_done)
    begin
      {data3_d, data2_d, data0_d} = {ind_read_data[31:16], ind_read_data[7:0]};
    end
    if (reg_wr)
    begin
      if (hit(reg_addr, `BEC_OFF_DATA0))
        data0_d = reg_wdata;
      else if (hit(reg_addr, `BEC_OFF_DATA2))
        data2_d = reg_wdata;
      else if (hit(reg_addr, `BEC_OFF_DATA3))
        data3_d = reg_wdata;
      else if (hit(reg_addr, `BEC_OFF_CTL))
      begin
        ctl_d.clk_src = reg_wdata[`BEC_CTL_CLK_SRC];
        ctl_d.clk_en = reg_wdata[`BEC_CTL_CLK_EN];
        // A busy engine keeps its bits; a fresh request arms clear only together with reload
        if (st_q == BEC_IDLE)
        begin
          ctl_d.reload = reg_wdata[`BEC_CTL_RELOAD];
          ctl_d.clear = reg_wdata[`BEC_CTL_CLEAR] && reg_wdata[`BEC_CTL_RELOAD];
        end
      end
      else if (hit(reg_addr, `BEC_OFF_ID))
      begin
        chn_d.slave = reg_wdata[7:1];
        chn_d.write_protect = reg_wdata[0];
      end
      else if (hit(reg_addr, `BEC_OFF_TIMA))
      begin
        chn_d.hold = reg_wdata[6:4];
        chn_d.filter = reg_wdata[3:0];
      end
      else if (hit(reg_addr, `BEC_OFF_TIMB))
        chn_d.delay = reg_wdata[1:0];
    end
    // Completion clears both bits
    if (st_q == BEC_DONE)
    begin
      ctl_d.reload = 1'b0;
      ctl_d.clear = 1'b0;
    end
  end

  // Flags: done only follows config done; remote load is sticky
  always_comb
  begin
    cfg_done_d = cfg_done_q || cfg_auto_done;
    init_done_d = init_done_q || (cfg_done_q && st_q == BEC_DONE);
    if (st_q == BEC_IDLE && ctl_q.reload)
      init_done_d = 1'b0;
    remote_d = remote_q || remote_load_pulse;
  end

  // Read mux; reserved bits read zero
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      if (hit(reg_addr, `BEC_OFF_DATA0))
        rdata_d = data0_q;
      else if (hit(reg_addr, `BEC_OFF_DATA2))
        rdata_d = data2_q;
      else if (hit(reg_addr, `BEC_OFF_DATA3))
        rdata_d = data3_q;
      else if (hit(reg_addr, `BEC_OFF_CTL))
        rdata_d = {3'h0, ctl_q.clk_src, ctl_q.clk_en, ctl_q.clear, ctl_q.reload,
                   ctl_q.block};
      else if (hit(reg_addr, `BEC_OFF_STS))
        rdata_d = {pins_s[1], pins_s[0], 1'b0, init_done_q, remote_q, cfg_done_q,
                   cfg_ck_q, id_ck_q};
      else if (hit(reg_addr, `BEC_OFF_ID))
        rdata_d = {chn_q.slave, chn_q.write_protect};
      else if (hit(reg_addr, `BEC_OFF_TIMA))
        rdata_d = {1'b0, chn_q.hold, chn_q.filter};
      else if (hit(reg_addr, `BEC_OFF_TIMB))
        rdata_d = {6'h00, chn_q.delay};
      else
        rdata_d = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      data0_q <= `BEC_RST_DATA;
      data2_q <= `BEC_RST_DATA;
      data3_q <= `BEC_RST_DATA;
      ctl_q <= '0;
      chn_q <= '{hold: `BEC_RST_HOLD, filter: `BEC_RST_FILTER, delay: `BEC_RST_DELAY,
                 slave: 7'(`BEC_RST_ID >> 1), write_protect: 1'b0};
      strap_wait_q <= 2'h0;
      cfg_done_q <= 1'b0;
      init_done_q <= 1'b0;
      remote_q <= 1'b0;
      cfg_ck_q <= 1'b0;
      id_ck_q <= 1'b0;
      st_q <= BEC_IDLE;
      cnt_q <= '0;
      sum_q <= '0;
      cfg_sum_q <= '0;
      rdata_q <= '0;
    end
    else
    begin
      data0_q <= data0_d;
      data2_q <= data2_d;
      data3_q <= data3_d;
      ctl_q <= ctl_d;
      chn_q <= chn_d;
      strap_wait_q <= strap_wait_d;
      cfg_done_q <= cfg_done_d;
      init_done_q <= init_done_d;
      remote_q <= remote_d;
      cfg_ck_q <= cfg_ck_d;
      id_ck_q <= id_ck_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      cfg_sum_q <= cfg_sum_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; timing counts are whole clock cycles, rounded up
  assign reg_rdata = rdata_q;
  assign chan_cfg = chn_q;
  assign consumer_ctl_clock_enable = ctl_q.clk_en;
  assign consumer_ctl_clock_source = ctl_q.clk_src;
  assign hold_cycles = 8'((32'(chn_q.hold) * `BEC_HOLD_UNIT_NS + `BEC_CLK_NS - 1)
                       / `BEC_CLK_NS);
  assign filter_cycles = 8'((32'(chn_q.filter) * `BEC_FILTER_UNIT_NS + `BEC_CLK_NS - 1)
                         / `BEC_CLK_NS);
  assign delay_cycles = 8'((`BEC_DELAY_BASE_NS + 32'(chn_q.delay) * `BEC_DELAY_STEP_NS
                        + `BEC_CLK_NS - 1) / `BEC_CLK_NS);
endmodule

// ==== tb/bec_regs_properties.sv ====
`timescale 1ns/1ps
module bec_regs_checker
  import bec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic ind_read_done,
  // Channel and settings
  input wire logic chan_wr,
  input wire logic chan_ack_n,
  input wire bec_chan_s chan_cfg,
  input wire logic consumer_ctl_clock_enable,
  input wire logic consumer_ctl_clock_source,
  input wire logic [7:0] hold_cycles,
  input wire logic [7:0] filter_cycles,
  input wire logic [7:0] delay_cycles
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Written byte comes back on the next read unless a fetch landed between
  property p_byte_two;
    (reg_wr && reg_addr == 8'h4d && !ind_read_done) ##1
    (reg_rd && reg_addr == 8'h4d && !ind_read_done) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_byte_two: assert property (p_byte_two) else $error("byte two readback wrong");
  property p_unmapped;
    reg_rd && reg_addr > 8'h53 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_timb_rsvd;
    reg_rd && reg_addr == 8'h53 |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_timb_rsvd: assert property (p_timb_rsvd) else $error("reserved bits set");
  // Cycle figures are rounded up so the delay never falls short
  property p_hold;
    hold_cycles == (chan_cfg.hold * 40 + 49) / 50;
  endproperty
  a_hold: assert property (p_hold) else $error("hold cycles wrong");
  property p_filter;
    filter_cycles == (chan_cfg.filter * 5 + 49) / 50;
  endproperty
  a_filter: assert property (p_filter) else $error("filter cycles wrong");
  property p_delay;
    delay_cycles == (chan_cfg.delay * 40 + 289) / 50;
  endproperty
  a_delay: assert property (p_delay) else $error("delay cycles wrong");
  property p_protect;
    chan_wr && chan_cfg.write_protect |-> chan_ack_n;
  endproperty
  a_protect: assert property (p_protect) else $error("protected write taken");
  property p_source;
    (reg_wr && reg_addr == 8'h4f) ##1 !reg_wr |=> consumer_ctl_clock_source == $past(reg_wdata[4], 2);
  endproperty
  a_source: assert property (p_source) else $error("clock source wrong");
  property p_enable;
    (reg_wr && reg_addr == 8'h4f) ##1 !reg_wr |=> consumer_ctl_clock_enable == $past(reg_wdata[3], 2);
  endproperty
  a_enable: assert property (p_enable) else $error("clock enable wrong");
endmodule
bind bec_regs bec_regs_checker u_chk (.mclk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .ind_read_done, .chan_wr, .chan_ack_n, .chan_cfg, .consumer_ctl_clock_enable,
  .consumer_ctl_clock_source, .hold_cycles, .filter_cycles, .delay_cycles);

// ==== tb/bec_host.sv ====
`timescale 1ns/1ps
module bec_host
(
  // Clock
  input wire logic mclk,
  // Register port towards the block
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  ////////////////////////////////////////
  // One access a cycle; strobes stay up so back-to-back accesses never glitch
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1;
  endtask
  // Released bus shows inverted values so stale data cannot pass as valid
  task automatic idle(input int n);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Quiet bus at time zero
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb
  import bec_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n, reg_wr, reg_rd, ind_read_done, strap_pin_zero, five_volt_detect_pin, rx_int_pin;
  logic cfg_auto_done, ee_valid, ee_last, ee_ready, chan_rd, chan_wr, chan_ack_n;
  logic remote_load_pulse;
  logic consumer_ctl_clock_enable, consumer_ctl_clock_source;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ee_data, chan_addr, chan_wdata, chan_rdata;
  logic [7:0] hold_cycles, filter_cycles, delay_cycles, d;
  logic [31:0] ind_read_data;
  bec_chan_s chan_cfg;
  int mismatches = 0;
  int checked = 0;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic [7:0] img [256];
  logic rd_seen = 1'b0;
  ////////////////////////////////////////
  // 20 MHz clock
  always #25 mclk = ~mclk;
  bec_host u_bec_host (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  bec_regs u_bec_regs (.mclk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .ind_read_start(1'b0), .ind_read_done, .ind_read_data, .strap_pin_zero,
    .five_volt_detect_pin, .rx_int_pin, .cfg_auto_done, .remote_load_pulse, .ee_valid,
    .ee_data, .ee_last, .ee_ready, .ee_start(), .chan_rd, .chan_wr, .chan_addr, .chan_wdata,
    .chan_rdata, .chan_ack_n, .chan_cfg, .consumer_ctl_clock_enable, .consumer_ctl_clock_source,
    .hold_cycles, .filter_cycles, .delay_cycles);
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Masked read note; the answer is compared by the watcher below
  task automatic rdm(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
    exp_q.push_back({m, v});
    u_bec_host.op(1'b0, a, 8'h00);
    u_bec_host.idle(1);
  endtask
  task automatic rdq(input logic [7:0] a, input logic [7:0] v);
    rdm(a, v, 8'hff);
  endtask
  // Poll until the self-clearing bits drop, bounded
  task automatic poll(input logic [7:0] m);
    int t;
    t = 0;
    do
    begin
      // Reserved bits and the unstrapped block bit stay low while polling
      exp_q.push_back({8'he1, 8'h00});
      u_bec_host.op(1'b0, 8'h4f, 8'h00);
      t++;
    end
    while ((reg_rdata & m) !== 8'h00 && t < 2000);
    u_bec_host.idle(1);
    if (t >= 2000)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // Channel read; data follows chan_addr one cycle later, with or without the request
  task automatic chan_read(input logic [7:0] a, input logic [7:0] v);
    chan_rd = 1'b1;
    chan_addr = a;
    @(posedge mclk);
    #1;
    check("channel read", chan_rdata, v);
    chan_rd = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  // Byte stream; data changes only after the block took the previous byte
  task automatic feed;
    int n;
    int t;
    logic [7:0] s;
    logic took;
    n = 0;
    t = 0;
    s = 8'h00;
    ee_valid = 1'b1;
    ee_data = 8'($urandom);
    while (n < 256 && t < 3000)
    begin
      // Ready is settled between edges; sampling it at the edge would race
      took = ee_ready;
      @(posedge mclk);
      #1;
      t++;
      if (took)
      begin
        img[n] = ee_data;
        s = (n == 127) ? 8'h00 : s + ee_data;
        n++;
        // Bytes 127 and 255 close each half to a zero sum
        ee_data = (n == 127 || n == 255) ? 8'h00 - s : 8'($urandom);
        ee_last = (n == 255);
      end
    end
    ee_valid = 1'b0;
    ee_last = 1'b0;
    if (t >= 3000)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  ////////////////////////////////////////
  // Watcher: each read answer is matched with the oldest note
  always @(posedge mclk)
  begin
    if (rd_seen && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check("register read", reg_rdata & note[15:8], note[7:0] & note[15:8]);
    end
    rd_seen <= reg_rd && reset_n;
  end
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    ind_read_done = 1'b0;
    strap_pin_zero = 1'b0;
    cfg_auto_done = 1'b0;
    remote_load_pulse = 1'b0;
    ee_valid = 1'b0;
    ee_last = 1'b0;
    chan_rd = 1'b0;
    chan_wr = 1'b0;
    chan_addr = 8'h00;
    chan_wdata = 8'h00;
    ee_data = 8'h00;
    ind_read_data = 32'h0;
    five_volt_detect_pin = 1'b1;
    rx_int_pin = 1'b1;
    void'($urandom(32'he2a4));
    repeat (3) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    u_bec_host.idle(4);
    rdq(8'h4d, 8'h00);
    rdq(8'h4e, 8'h00);
    rdq(8'h4f, 8'h00);
    rdq(8'h50, 8'hc0);
    rdq(8'h51, 8'ha0);
    rdq(8'h52, 8'h1e);
    rdq(8'h53, 8'h00);
    rdq(8'h60, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      u_bec_host.op(1'b1, 8'h52, d);
      u_bec_host.op(1'b1, 8'h53, d);
      u_bec_host.op(1'b1, 8'h4d, d);
      rdq(8'h4d, d);
      rdq(8'h52, d & 8'h7f);
      rdq(8'h53, d & 8'h03);
    end
    // Protected memory refuses a channel write
    u_bec_host.op(1'b1, 8'h51, 8'ha3);
    rdq(8'h51, 8'ha3);
    chan_wr = 1'b1;
    chan_addr = 8'h10;
    chan_wdata = 8'h55;
    #10;
    check("channel ack", {7'h00, chan_ack_n}, 8'h01);
    @(posedge mclk);
    #1;
    chan_wr = 1'b0;
    u_bec_host.op(1'b1, 8'h51, 8'ha0);
    // Fetched word lands in bytes zero, two and three
    ind_read_data = $urandom;
    ind_read_done = 1'b1;
    u_bec_host.idle(1);
    ind_read_done = 1'b0;
    rdq(8'h4b, ind_read_data[7:0]);
    rdq(8'h4d, ind_read_data[23:16]);
    rdq(8'h4e, ind_read_data[31:24]);
    for (int k = 0; k < 4; k++)
    begin
      u_bec_host.op(1'b1, 8'h4f, {3'h0, 2'(k), 3'h0});
      u_bec_host.idle(2);
      check("consumer clock", {6'h00, consumer_ctl_clock_source, consumer_ctl_clock_enable},
        {6'h00, 2'(k)});
    end
    // Clear alone is dropped
    u_bec_host.op(1'b1, 8'h4f, 8'h04);
    rdq(8'h4f, 8'h00);
    cfg_auto_done = 1'b1;
    u_bec_host.idle(1);
    cfg_auto_done = 1'b0;
    u_bec_host.op(1'b1, 8'h4f, 8'h02);
    u_bec_host.idle(1);
    feed();
    poll(8'h06);
    rdm(8'h50, 8'hd7, 8'hff);
    chan_read(8'h10, img[16]);
    chan_read(8'hff, img[255]);
    // Clear and reload together wipe the memory
    u_bec_host.op(1'b1, 8'h4f, 8'h06);
    u_bec_host.idle(1);
    poll(8'h06);
    chan_read(8'h10, 8'h00);
    // Open memory takes a channel write
    chan_addr = 8'h20;
    chan_wdata = 8'($urandom);
    chan_wr = 1'b1;
    #10;
    check("open ack", {7'h00, chan_ack_n}, 8'h00);
    @(posedge mclk);
    #1;
    chan_wr = 1'b0;
    chan_read(8'h20, chan_wdata);
    // Pins drop and a remote load is reported
    five_volt_detect_pin = 1'b0;
    rx_int_pin = 1'b0;
    remote_load_pulse = 1'b1;
    u_bec_host.idle(1);
    remote_load_pulse = 1'b0;
    u_bec_host.idle(3);
    rdm(8'h50, 8'h08, 8'hc8);
    // Second reset with the strap high blocks the channel
    strap_pin_zero = 1'b1;
    reset_n = 1'b0;
    u_bec_host.idle(3);
    reset_n = 1'b1;
    u_bec_host.idle(6);
    rdq(8'h4f, 8'h01);
    chan_rd = 1'b1;
    #10;
    check("blocked ack", {7'h00, chan_ack_n}, 8'h01);
    @(posedge mclk);
    #1;
    chan_rd = 1'b0;
    u_bec_host.idle(2);
    tally_and_finish();
  end
endmodule
